// >>> dtmc_pkg.sv
// constants for the die temperature measurement controller
package dtmc_pkg;
  // ==========================================
  // clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SENSOR_CLK_HZ = 1_000_000;
  localparam int unsigned UNIT_SENSOR_TICKS = 256;
  localparam int unsigned UNIT_CYCLES = UNIT_SENSOR_TICKS * (CLK_HZ / SENSOR_CLK_HZ);
  localparam int unsigned TAIL_US = 32;
  localparam int unsigned TAIL_CYCLES = (TAIL_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                        TAIL_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 32;

  // ==========================================
  // register map (address, page)
  localparam logic [7:0] ADDR_CTRL = 8'hD2;
  localparam logic [7:0] ADDR_RES_LOW = 8'hD2;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hD3;
  localparam logic [7:0] PAGE_CTRL = 8'h0F;
  localparam logic [7:0] PAGE_DATA = 8'h00;

  // ==========================================
  // control register fields and reset values
  localparam int BIT_TRIGGER = 7;
  localparam int BIT_DONE = 6;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_RES_LOW = 8'h00;
  localparam logic [7:0] RST_RES_HIGH = 8'h00;
  localparam int RESULT_W = 16;
endpackage

// >>> dtmc_tb.sv
// self-checking bench for the die temperature measurement controller
`timescale 1ns/1ns
module tb;
  localparam int unsigned UNIT = 4;
  localparam int unsigned TAIL = 2;
  localparam logic [7:0] CPG = 8'h0F;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_page = 8'h00;
  logic sfr_we = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic temp_irq_enable = 1'b0;
  logic [15:0] sensor_sample = 16'h0000;
  logic sensor_enable;
  logic temp_irq;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_exp;
  int k;
  logic [7:0] got;
  logic [2:0] sel;
  logic [15:0] smp;
  logic [15:0] exp_q[$];
  logic [15:0] exp_w;

  // ==========================================
  // clock and design
  always #25 clk = ~clk;

  dtmc_top #(.UNIT_CYCLES(UNIT), .TAIL_CYCLES(TAIL)) i_dut (
    .clk(clk),
    .resetn(resetn),
    .sfr_addr(sfr_addr),
    .sfr_page(sfr_page),
    .sfr_we(sfr_we),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .temp_irq_enable(temp_irq_enable),
    .sensor_sample(sensor_sample),
    .sensor_enable(sensor_enable),
    .temp_irq(temp_irq)
  );

  // ==========================================
  // tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_page = pg;
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_we = 1'b1;
    @(posedge clk);
    #1;
    sfr_we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] pg, input logic [7:0] ad);
    @(posedge clk);
    #1;
    sfr_page = pg;
    sfr_addr = ad;
    #2;
    got = sfr_rdata;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================
  // timeout
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h24C711FB));
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    rd(CPG, 8'hD2);
    chk("ctrl rst", 16'h0000, {8'h00, got});
    rd(8'h00, 8'hD2);
    chk("low rst", 16'h0000, {8'h00, got});
    rd(8'h00, 8'hD3);
    chk("high rst", 16'h0000, {8'h00, got});
    wr(8'h05, 8'hD2, 8'hFF);
    rd(8'h05, 8'hD2);
    chk("unmapped", 16'h0000, {8'h00, got});
    rd(CPG, 8'hD2);
    chk("ctrl kept", 16'h0000, {8'h00, got});
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      #1;
      sel = s[2:0];
      smp = 16'($urandom());
      sensor_sample = smp;
      temp_irq_enable = 1'($urandom());
      n_exp = UNIT * ((1 << (s + 1)) + 1) + TAIL;
      wr(CPG, 8'hD2, 8'hC0 | {5'h00, sel});
      rd(CPG, 8'hD2);
      chk("ctrl set", {8'h00, 8'h80 | {5'h00, sel}}, {8'h00, got});
      chk("idle on set", 16'h0000, {15'h0000, sensor_enable});
      wr(CPG, 8'hD2, {5'h00, sel});
      exp_q.push_back(smp);
      k = 0;
      got = 8'h00;
      while (got[6] !== 1'b1 && k < 2000) begin
        rd(CPG, 8'hD2);
        k++;
        if (k == 1) chk("busy", 16'h0001, {15'h0000, sensor_enable});
      end
      chk("duration", 16'(n_exp), 16'(k));
      chk("irq", {15'h0000, temp_irq_enable}, {15'h0000, temp_irq});
      exp_w = exp_q.pop_front();
      rd(8'h00, 8'hD3);
      chk("high", {8'h00, exp_w[15:8]}, {8'h00, got});
      rd(8'h00, 8'hD2);
      chk("low", {8'h00, exp_w[7:0]}, {8'h00, got});
      repeat (4) @(posedge clk);
      rd(CPG, 8'hD2);
      chk("done held", {8'h00, 8'h40 | {5'h00, sel}}, {8'h00, got});
      chk("stopped", 16'h0000, {15'h0000, sensor_enable});
      wr(CPG, 8'hD2, {5'h00, sel});
      rd(CPG, 8'hD2);
      chk("done clr", {8'h00, 5'h00, sel}, {8'h00, got});
      chk("irq clr", 16'h0000, {15'h0000, temp_irq});
      chk("no restart", 16'h0000, {15'h0000, sensor_enable});
      $display("test sel %0d done", s);
    end
    wr(CPG, 8'hD2, 8'h83);
    wr(CPG, 8'hD2, 8'h03);
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b0;
    #1;
    chk("rst idle", 16'h0000, {15'h0000, sensor_enable});
    @(posedge clk);
    #1;
    resetn = 1'b1;
    rd(8'h00, 8'hD3);
    chk("rst high", 16'h0000, {8'h00, got});
    repeat (80) @(posedge clk);
    rd(CPG, 8'hD2);
    chk("rst no done", 16'h0000, {8'h00, got});
    chk("rst no run", 16'h0000, {15'h0000, sensor_enable});
    $display("test mid reset done");
    n_exp = UNIT * 3 + TAIL;
    wr(CPG, 8'hD2, 8'h80);
    wr(CPG, 8'hD2, 8'h00);
    repeat (n_exp - 2) @(posedge clk);
    wr(CPG, 8'hD2, 8'h00);
    rd(CPG, 8'hD2);
    chk("set wins", 16'h0040, {8'h00, got});
    wr(CPG, 8'hD2, 8'h00);
    rd(CPG, 8'hD2);
    chk("race clr", 16'h0000, {8'h00, got});
    $display("test clear race done");
    wr(8'h00, 8'hD2, 8'h5A);
    rd(8'h00, 8'hD2);
    chk("low rw", 16'h005A, {8'h00, got});
    wr(8'h00, 8'hD3, 8'hA5);
    rd(8'h00, 8'hD3);
    chk("high rw", 16'h00A5, {8'h00, got});
    $display("test data rw done");
    end_of_test();
  end
endmodule

// >>> dtmc_top.sv
// die temperature measurement control, result and flag registers
`timescale 1ns/1ns
module dtmc_top #(
  parameter int unsigned UNIT_CYCLES = dtmc_pkg::UNIT_CYCLES,
  parameter int unsigned TAIL_CYCLES = dtmc_pkg::TAIL_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_we,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic temp_irq_enable,
  input wire logic [15:0] sensor_sample,
  output logic sensor_enable,
  output logic temp_irq
);

  // ==========================================
  // state and storage
  typedef enum logic {DTMC_IDLE, DTMC_MEASURE} dtmc_state_t;

  dtmc_state_t state_reg;
  logic measure_trigger_reg;
  logic measure_done_flag_reg;
  logic [dtmc_pkg::SEL_W-1:0] conversion_length_sel_reg;
  logic [7:0] temp_result_high_reg;
  logic [7:0] temp_result_low_reg;
  logic [dtmc_pkg::CNT_W-1:0] cnt_reg;
  logic [dtmc_pkg::CNT_W-1:0] cnt_next;

  logic sel_ctrl;
  logic sel_low;
  logic sel_high;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic start_pulse;
  logic finish_pulse;

  // ==========================================
  // address decode
  assign sel_ctrl = (sfr_addr == dtmc_pkg::ADDR_CTRL) && (sfr_page == dtmc_pkg::PAGE_CTRL);
  assign sel_low = (sfr_addr == dtmc_pkg::ADDR_RES_LOW) && (sfr_page == dtmc_pkg::PAGE_DATA);
  assign sel_high = (sfr_addr == dtmc_pkg::ADDR_RES_HIGH) && (sfr_page == dtmc_pkg::PAGE_DATA);
  assign wr_ctrl = sfr_we && sel_ctrl;
  assign wr_low = sfr_we && sel_low;
  assign wr_high = sfr_we && sel_high;

  // length in clock cycles for a selector value
  function automatic logic [dtmc_pkg::CNT_W-1:0] length_cycles(
    input logic [dtmc_pkg::SEL_W-1:0] sel
  );
    logic [dtmc_pkg::CNT_W-1:0] mult;
    mult = (32'h0000_0001 << (sel + 4'h1)) + 32'h0000_0001;
    length_cycles = UNIT_CYCLES[dtmc_pkg::CNT_W-1:0] * mult + TAIL_CYCLES[dtmc_pkg::CNT_W-1:0];
  endfunction

  // ==========================================
  // trigger edge detection
  // start on falling trigger
  assign start_pulse = wr_ctrl && measure_trigger_reg && !sfr_wdata[dtmc_pkg::BIT_TRIGGER]
                       && (state_reg == DTMC_IDLE);
  assign finish_pulse = (state_reg == DTMC_MEASURE) && (cnt_reg == 32'h0000_0001);

  // ==========================================
  // control register fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      measure_trigger_reg <= dtmc_pkg::RST_CTRL[dtmc_pkg::BIT_TRIGGER];
      conversion_length_sel_reg <= dtmc_pkg::RST_CTRL[dtmc_pkg::SEL_MSB:dtmc_pkg::SEL_LSB];
    end else if (wr_ctrl) begin
      measure_trigger_reg <= sfr_wdata[dtmc_pkg::BIT_TRIGGER];
      conversion_length_sel_reg <= sfr_wdata[dtmc_pkg::SEL_MSB:dtmc_pkg::SEL_LSB];
    end
  end

  // ==========================================
  // done flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      measure_done_flag_reg <= dtmc_pkg::RST_CTRL[dtmc_pkg::BIT_DONE];
    end else if (finish_pulse) begin
      measure_done_flag_reg <= 1'b1;
    end else if (wr_ctrl && !sfr_wdata[dtmc_pkg::BIT_DONE]) begin
      measure_done_flag_reg <= 1'b0;
    end
  end

  // ==========================================
  // measurement sequencer
  always_comb begin
    cnt_next = cnt_reg;
    case (state_reg)
      DTMC_IDLE: begin
        if (start_pulse) begin
          cnt_next = length_cycles(sfr_wdata[dtmc_pkg::SEL_MSB:dtmc_pkg::SEL_LSB]);
        end
      end
      DTMC_MEASURE: begin
        cnt_next = cnt_reg - 32'h0000_0001;
      end
      default: begin
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= DTMC_IDLE;
    end else begin
      case (state_reg)
        DTMC_IDLE: begin
          if (start_pulse) begin
            state_reg <= DTMC_MEASURE;
          end
        end
        DTMC_MEASURE: begin
          if (finish_pulse) begin
            state_reg <= DTMC_IDLE;
          end
        end
        default: begin
          state_reg <= DTMC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sensor_enable <= 1'b0;
    end else begin
      sensor_enable <= (state_reg == DTMC_MEASURE) ? !finish_pulse : start_pulse;
    end
  end

  // ==========================================
  // result registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      temp_result_high_reg <= dtmc_pkg::RST_RES_HIGH;
      temp_result_low_reg <= dtmc_pkg::RST_RES_LOW;
    end else if (finish_pulse) begin
      temp_result_high_reg <= sensor_sample[15:8];
      temp_result_low_reg <= sensor_sample[7:0];
    end else begin
      if (wr_high) begin
        temp_result_high_reg <= sfr_wdata;
      end
      if (wr_low) begin
        temp_result_low_reg <= sfr_wdata;
      end
    end
  end

  // ==========================================
  // read mux and interrupt
  always_comb begin
    sfr_rdata = 8'h00;
    if (sel_ctrl) begin
      sfr_rdata[dtmc_pkg::BIT_TRIGGER] = measure_trigger_reg;
      sfr_rdata[dtmc_pkg::BIT_DONE] = measure_done_flag_reg;
      sfr_rdata[dtmc_pkg::SEL_MSB:dtmc_pkg::SEL_LSB] = conversion_length_sel_reg;
    end else if (sel_high) begin
      sfr_rdata = temp_result_high_reg;
    end else if (sel_low) begin
      sfr_rdata = temp_result_low_reg;
    end
  end

  assign temp_irq = measure_done_flag_reg && temp_irq_enable;

  // ==========================================
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_start_on_fall: assert property (
    start_pulse |=> (state_reg == DTMC_MEASURE) && sensor_enable)
    else $error("falling trigger did not start a measurement");

  a_no_start_on_set: assert property (
    (state_reg == DTMC_IDLE) && wr_ctrl && sfr_wdata[dtmc_pkg::BIT_TRIGGER]
    |=> (state_reg == DTMC_IDLE))
    else $error("setting trigger alone started a measurement");

  a_length_load: assert property (
    start_pulse |=> cnt_reg == length_cycles($past(sfr_wdata[dtmc_pkg::SEL_MSB:dtmc_pkg::SEL_LSB])))
    else $error("conversion length count wrong");

  a_done_on_finish: assert property (
    finish_pulse |=> measure_done_flag_reg && (state_reg == DTMC_IDLE) && !sensor_enable)
    else $error("done flag not set at completion");

  a_done_sticky: assert property (
    measure_done_flag_reg && !(wr_ctrl && !sfr_wdata[dtmc_pkg::BIT_DONE])
    |=> measure_done_flag_reg)
    else $error("done flag cleared without firmware");

  a_irq_follow: assert property (
    $rose(measure_done_flag_reg) && temp_irq_enable |-> temp_irq)
    else $error("interrupt not raised on done");

  a_irq_gate: assert property (
    !temp_irq_enable |-> !temp_irq)
    else $error("interrupt raised while disabled");

  a_result_load: assert property (
    $rose(measure_done_flag_reg)
    |-> {temp_result_high_reg, temp_result_low_reg} == $past(sensor_sample))
    else $error("result not loaded with done flag");

  a_sel_store: assert property (
    wr_ctrl |=> conversion_length_sel_reg == $past(sfr_wdata[dtmc_pkg::SEL_MSB:dtmc_pkg::SEL_LSB]))
    else $error("selector not stored");

  a_high_read: assert property (
    sel_high |-> sfr_rdata == temp_result_high_reg)
    else $error("high byte read wrong");

  c_measure_start: cover property (start_pulse);
  c_measure_done: cover property (finish_pulse ##1 temp_irq);
  c_clear_race: cover property (finish_pulse && wr_ctrl && !sfr_wdata[dtmc_pkg::BIT_DONE]);
  c_long_sel: cover property (start_pulse && sfr_wdata[dtmc_pkg::SEL_MSB:dtmc_pkg::SEL_LSB] == 3'h7);

endmodule
